// file: shared/qdac_pkg.sv
// Register map, field positions and carrier types for the quad converter update and configuration block.
// Assumes the serial front end hands over already decoded byte-wide register accesses.
package qdac_pkg;

    localparam logic [7:0] DAC_A_LSB_ADDR  = 8'h10;
    localparam logic [7:0] DAC_A_MSB_ADDR  = 8'h11;
    localparam logic [7:0] OPMODE_ADDR     = 8'h1a;
    localparam logic [7:0] CONV_CFG_ADDR   = 8'h1b;
    localparam logic [7:0] UPD_CMD_ADDR    = 8'h1c;
    localparam logic [7:0] REG_RESET_VAL   = 8'h00;

    // Operating-mode register fields
    localparam int OPM_ADC_FAST_BIT   = 0;
    localparam int OPM_THERM_10B_BIT  = 1;
    localparam int OPM_REG_UPD_BIT    = 3;
    localparam int OPM_A_FOLLOW_BIT   = 5;
    localparam int OPM_B_FOLLOW_BIT   = 6;

    // Converter configuration register fields
    localparam int CFG_RANGE_LSB      = 0;
    localparam int CFG_MODE_LSB       = 4;
    localparam int CFG_BYP_AB_BIT     = 6;
    localparam int CFG_BYP_CD_BIT     = 7;

    // Update-command register fields
    localparam int CMD_VREF_INT_BIT   = 4;

    localparam int TEMP_BITS          = 10;

    typedef enum logic [1:0] {
        QDAC_UPD_SINGLE,
        QDAC_UPD_PAIR,
        QDAC_UPD_ALL,
        QDAC_UPD_CMD
    } qdac_upd_mode_e;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } qdac_req_s;

    typedef struct packed {
        logic       adc_fast;
        logic       filter_off;
        logic       therm_10b;
        logic       reg_upd;
        logic [3:0] range_2x;
        logic       byp_ab;
        logic       byp_cd;
        logic       vref_int;
    } qdac_cfg_s;

endpackage

// file: verilog/qdac_update_ctrl.sv
// Configuration registers and output-update control for four converter channels.
// Assumes register accesses and temperature codes arrive on sys_clk_in; the update pin is asynchronous.
//
// Contract
// - Operating-mode register, eight bits read/write, resets to zero.
// - Bit 0 selects fast converter clock and disables remote-diode filters.
// - Bit 1 picks 8-bit or 10-bit thermal output resolution.
// - Bit 3 picks update pin or registers as update source.
// - Bit 5 makes channel A follow internal temperature.
// - Bit 6 makes channel B follow external temperature.
// - Converter configuration register, eight bits read/write, resets to zero.
// - Bits 0 to 3 select per-channel range, A to D.
// - Update-mode field acts only while register updating is selected.
// - Mode 00: MSB write updates that channel only.
// - Mode 01: MSB write to B updates A,B; to D updates C,D.
// - Mode 10: MSB write to D updates all four channels.
// - Mode 11: only update-command register updates; data writes do not.
// - Bit 6 bypasses reference buffer for channels A and B.
// - Bit 7 bypasses reference buffer for channels C and D.
// - Update-command bits 0 to 3 strobe channel updates in mode 11 only, read back zero.
// - Code joins MSB and LSB registers; outputs zero after reset.
`timescale 1ns/1ps
`default_nettype none

module qdac_update_ctrl #(
    parameter int DAC_BITS = 12
) (
    input  wire logic                         sys_clk_in,
    input  wire logic                         resetn_in,
    input  wire qdac_pkg::qdac_req_s          reg_req_in,
    output logic [7:0]                        reg_rdata_out,
    input  wire logic                         output_update_strobe_n_in,
    input  wire logic [qdac_pkg::TEMP_BITS-1:0] int_temp_in,
    input  wire logic [qdac_pkg::TEMP_BITS-1:0] ext_temp_in,
    output logic [4*DAC_BITS-1:0]             dac_code_out,
    output logic [3:0]                        dac_updated_out,
    output qdac_pkg::qdac_cfg_s               cfg_out,
    output logic                              a_follow_int_out,
    output logic                              b_follow_ext_out
);

    localparam int LSB_BITS = DAC_BITS - 8;

    logic [7:0]          opmode_reg;
    logic [7:0]          conv_cfg_reg;
    logic                vref_int_reg;
    logic [7:0]          msb_reg [4];
    logic [7:0]          lsb_reg [4];
    logic [DAC_BITS-1:0] out_reg [4];
    logic [DAC_BITS-1:0] in_next [4];
    logic [DAC_BITS-1:0] temp_code [2];
    logic [3:0]          msb_wr;
    logic [3:0]          lsb_wr;
    logic [3:0]          upd_next;
    logic [3:0]          upd_reg;
    logic                pin_sync1_reg;
    logic                pin_sync2_reg;
    logic                reg_ctrl;
    logic                cmd_wr;
    qdac_pkg::qdac_upd_mode_e mode;

    assign reg_ctrl = opmode_reg[qdac_pkg::OPM_REG_UPD_BIT];
    assign mode     = qdac_pkg::qdac_upd_mode_e'(conv_cfg_reg[qdac_pkg::CFG_MODE_LSB +: 2]);
    assign cmd_wr   = reg_req_in.wr && (reg_req_in.addr == qdac_pkg::UPD_CMD_ADDR);

    // Pin is asynchronous to sys_clk_in
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            pin_sync1_reg <= 1'b1;
            pin_sync2_reg <= 1'b1;
        end else begin
            pin_sync1_reg <= output_update_strobe_n_in;
            pin_sync2_reg <= pin_sync1_reg;
        end
    end

    // Reserved operating-mode bits are stored as written; keeping them zero is up to the host
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            opmode_reg   <= qdac_pkg::REG_RESET_VAL;
            conv_cfg_reg <= qdac_pkg::REG_RESET_VAL;
            vref_int_reg <= 1'b0;
        end else if (reg_req_in.wr) begin
            if (reg_req_in.addr == qdac_pkg::OPMODE_ADDR) begin
                opmode_reg <= reg_req_in.wdata;
            end
            if (reg_req_in.addr == qdac_pkg::CONV_CFG_ADDR) begin
                conv_cfg_reg <= reg_req_in.wdata;
            end
            if (cmd_wr) begin
                vref_int_reg <= reg_req_in.wdata[qdac_pkg::CMD_VREF_INT_BIT];
            end
        end
    end

    // Temperature scaled into the converter width, left aligned
    function automatic logic [DAC_BITS-1:0] scale_temp(input logic [qdac_pkg::TEMP_BITS-1:0] t,
                                                       input logic res10);
        logic [15:0] wide;
        wide = res10 ? {t, 6'h00} : {t[9:2], 8'h00};
        return wide[15 -: DAC_BITS];
    endfunction

    assign temp_code[0] = scale_temp(int_temp_in, opmode_reg[qdac_pkg::OPM_THERM_10B_BIT]);
    assign temp_code[1] = scale_temp(ext_temp_in, opmode_reg[qdac_pkg::OPM_THERM_10B_BIT]);

    for (genvar i = 0; i < 4; i++) begin : g_chan
        localparam logic [7:0] LSB_ADDR = qdac_pkg::DAC_A_LSB_ADDR + 8'(2 * i);
        localparam logic [7:0] MSB_ADDR = qdac_pkg::DAC_A_MSB_ADDR + 8'(2 * i);

        assign msb_wr[i] = reg_req_in.wr && (reg_req_in.addr == MSB_ADDR);
        assign lsb_wr[i] = reg_req_in.wr && (reg_req_in.addr == LSB_ADDR);

        // New byte is visible to an update raised by the same write
        always_comb begin
            logic [7:0] msb_v;
            logic [7:0] lsb_v;
            msb_v      = msb_wr[i] ? reg_req_in.wdata : msb_reg[i];
            lsb_v      = lsb_wr[i] ? reg_req_in.wdata : lsb_reg[i];
            in_next[i] = {msb_v, lsb_v[7 -: LSB_BITS]};
        end

        always_ff @(posedge sys_clk_in) begin
            if (!resetn_in) begin
                msb_reg[i] <= 8'h00;
                lsb_reg[i] <= 8'h00;
            end else begin
                if (msb_wr[i]) begin
                    msb_reg[i] <= reg_req_in.wdata;
                end
                if (lsb_wr[i]) begin
                    lsb_reg[i] <= reg_req_in.wdata;
                end
            end
        end

        // Temperature-following channels track continuously; update strobes do not gate them
        always_ff @(posedge sys_clk_in) begin
            if (!resetn_in) begin
                out_reg[i] <= '0;
            end else if (i == 0 && opmode_reg[qdac_pkg::OPM_A_FOLLOW_BIT]) begin
                out_reg[i] <= temp_code[0];
            end else if (i == 1 && opmode_reg[qdac_pkg::OPM_B_FOLLOW_BIT]) begin
                out_reg[i] <= temp_code[1];
            end else if (upd_next[i]) begin
                out_reg[i] <= in_next[i];
            end
        end

        assign dac_code_out[i*DAC_BITS +: DAC_BITS] = out_reg[i];
    end

    // Update source and mode decode
    always_comb begin
        upd_next = 4'h0;
        if (!reg_ctrl) begin
            upd_next = pin_sync2_reg ? 4'h0 : 4'hf;
        end else begin
            unique case (mode)
                qdac_pkg::QDAC_UPD_SINGLE: upd_next = msb_wr;
                qdac_pkg::QDAC_UPD_PAIR:   upd_next = {msb_wr[3], msb_wr[3], msb_wr[1], msb_wr[1]};
                qdac_pkg::QDAC_UPD_ALL:    upd_next = {4{msb_wr[3]}};
                qdac_pkg::QDAC_UPD_CMD:    upd_next = cmd_wr ? reg_req_in.wdata[3:0] : 4'h0;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            upd_reg <= 4'h0;
        end else begin
            upd_reg <= upd_next;
        end
    end

    assign dac_updated_out = upd_reg;

    // Configuration outputs
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            cfg_out          <= '0;
            a_follow_int_out <= 1'b0;
            b_follow_ext_out <= 1'b0;
        end else begin
            cfg_out.adc_fast   <= opmode_reg[qdac_pkg::OPM_ADC_FAST_BIT];
            cfg_out.filter_off <= opmode_reg[qdac_pkg::OPM_ADC_FAST_BIT];
            cfg_out.therm_10b  <= opmode_reg[qdac_pkg::OPM_THERM_10B_BIT];
            cfg_out.reg_upd    <= reg_ctrl;
            cfg_out.range_2x   <= conv_cfg_reg[qdac_pkg::CFG_RANGE_LSB +: 4];
            cfg_out.byp_ab     <= conv_cfg_reg[qdac_pkg::CFG_BYP_AB_BIT];
            cfg_out.byp_cd     <= conv_cfg_reg[qdac_pkg::CFG_BYP_CD_BIT];
            cfg_out.vref_int   <= vref_int_reg;
            a_follow_int_out   <= opmode_reg[qdac_pkg::OPM_A_FOLLOW_BIT];
            b_follow_ext_out   <= opmode_reg[qdac_pkg::OPM_B_FOLLOW_BIT];
        end
    end

    // Read port; unmapped addresses read zero
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_req_in.rd) begin
            unique case (reg_req_in.addr)
                qdac_pkg::OPMODE_ADDR:    reg_rdata_out <= opmode_reg;
                qdac_pkg::CONV_CFG_ADDR:  reg_rdata_out <= conv_cfg_reg;
                qdac_pkg::UPD_CMD_ADDR:   reg_rdata_out <= {3'h0, vref_int_reg, 4'h0};
                qdac_pkg::DAC_A_LSB_ADDR:         reg_rdata_out <= lsb_reg[0];
                qdac_pkg::DAC_A_MSB_ADDR:         reg_rdata_out <= msb_reg[0];
                qdac_pkg::DAC_A_LSB_ADDR + 8'h02: reg_rdata_out <= lsb_reg[1];
                qdac_pkg::DAC_A_MSB_ADDR + 8'h02: reg_rdata_out <= msb_reg[1];
                qdac_pkg::DAC_A_LSB_ADDR + 8'h04: reg_rdata_out <= lsb_reg[2];
                qdac_pkg::DAC_A_MSB_ADDR + 8'h04: reg_rdata_out <= msb_reg[2];
                qdac_pkg::DAC_A_LSB_ADDR + 8'h06: reg_rdata_out <= lsb_reg[3];
                qdac_pkg::DAC_A_MSB_ADDR + 8'h06: reg_rdata_out <= msb_reg[3];
                default:                  reg_rdata_out <= 8'h00;
            endcase
        end
    end

    // Checks
    chk_opmode_reset: assert property (@(posedge sys_clk_in)
        !resetn_in |=> opmode_reg == 8'h00 && conv_cfg_reg == 8'h00)
        else $error("config registers not cleared by reset");

    chk_fast_filter: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        ##1 cfg_out.filter_off == $past(opmode_reg[qdac_pkg::OPM_ADC_FAST_BIT])
        && cfg_out.adc_fast == cfg_out.filter_off)
        else $error("filter disable does not track fast clock");

    chk_pin_ignored: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        reg_ctrl && !msb_wr[3] && !msb_wr[1] && !msb_wr[0] && !msb_wr[2] && !cmd_wr |=> upd_reg == 4'h0)
        else $error("update raised without register cause");

    chk_pin_update: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        !reg_ctrl && !pin_sync2_reg |=> upd_reg == 4'hf)
        else $error("pin low did not update all channels");

    chk_single_mode: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        reg_ctrl && mode == qdac_pkg::QDAC_UPD_SINGLE && msb_wr[2] |=> upd_reg == 4'b0100)
        else $error("single mode updated wrong channel");

    chk_pair_mode: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        reg_ctrl && mode == qdac_pkg::QDAC_UPD_PAIR && msb_wr[1] |=> upd_reg == 4'b0011)
        else $error("pair mode did not update A and B");

    chk_all_mode: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        reg_ctrl && mode == qdac_pkg::QDAC_UPD_ALL && msb_wr[3] |=> upd_reg == 4'hf)
        else $error("all mode did not update four channels");

    chk_cmd_mode: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        reg_ctrl && mode == qdac_pkg::QDAC_UPD_CMD && !cmd_wr |=> upd_reg == 4'h0)
        else $error("data write updated outputs in command mode");

    chk_cmd_copy: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        reg_ctrl && mode == qdac_pkg::QDAC_UPD_CMD && cmd_wr && reg_req_in.wdata[0]
        && !opmode_reg[qdac_pkg::OPM_A_FOLLOW_BIT] |=> out_reg[0] == $past(in_next[0]))
        else $error("command strobe did not load channel A");

    chk_range_out: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        ##1 cfg_out.range_2x == $past(conv_cfg_reg[3:0]))
        else $error("range outputs do not follow config");

    chk_opmode_write: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        reg_req_in.wr && reg_req_in.addr == qdac_pkg::OPMODE_ADDR |=> opmode_reg == $past(reg_req_in.wdata))
        else $error("operating-mode write not stored");

    chk_cfg_write: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        reg_req_in.wr && reg_req_in.addr == qdac_pkg::CONV_CFG_ADDR |=> conv_cfg_reg == $past(reg_req_in.wdata))
        else $error("converter configuration write not stored");

    chk_therm_out: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        ##1 cfg_out.therm_10b == $past(opmode_reg[qdac_pkg::OPM_THERM_10B_BIT]))
        else $error("resolution output does not follow config");

    chk_therm_res: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        !opmode_reg[qdac_pkg::OPM_THERM_10B_BIT]
        |-> temp_code[0][DAC_BITS-9:0] == '0 && temp_code[1][DAC_BITS-9:0] == '0)
        else $error("8-bit thermal code carries low bits");

    chk_follow_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        opmode_reg[qdac_pkg::OPM_A_FOLLOW_BIT] |=> out_reg[0] == $past(temp_code[0]))
        else $error("channel A does not follow internal temperature");

    chk_follow_b: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        opmode_reg[qdac_pkg::OPM_B_FOLLOW_BIT] |=> out_reg[1] == $past(temp_code[1]))
        else $error("channel B does not follow external temperature");

    chk_bypass_out: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        ##1 cfg_out.byp_ab == $past(conv_cfg_reg[qdac_pkg::CFG_BYP_AB_BIT])
        && cfg_out.byp_cd == $past(conv_cfg_reg[qdac_pkg::CFG_BYP_CD_BIT]))
        else $error("reference bypass outputs do not follow config");

    chk_code_reset: assert property (@(posedge sys_clk_in)
        !resetn_in |=> dac_code_out == '0 && dac_updated_out == 4'h0)
        else $error("outputs not cleared by reset");

    chk_cmd_readback: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        reg_req_in.rd && reg_req_in.addr == qdac_pkg::UPD_CMD_ADDR |=> reg_rdata_out[3:0] == 4'h0)
        else $error("update strobe bits did not read back zero");

    chk_pair_d: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        reg_ctrl && mode == qdac_pkg::QDAC_UPD_PAIR && msb_wr[3] |=> upd_reg == 4'hc)
        else $error("pair mode did not update C and D");

    chk_pin_only: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        !reg_ctrl && pin_sync2_reg |=> upd_reg == 4'h0)
        else $error("register write updated outputs in pin mode");

endmodule // qdac_update_ctrl

`default_nettype wire

// file: tb/qdac_host_model.sv
// Host model issuing decoded byte-wide register accesses to the update block.
// Assumes the block samples requests on the rising edge of sys_clk_in.
`timescale 1ns/1ps
`default_nettype none

module qdac_host_model (
    input  wire logic               sys_clk_in,
    input  wire logic [7:0]         rdata_in,
    output var qdac_pkg::qdac_req_s req_out
);
    initial req_out = '0;

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        logic [7:0] d;
        d = data;
        if (addr == qdac_pkg::OPMODE_ADDR) d = data & 8'h6b;
        @(negedge sys_clk_in);
        req_out = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: d};
        @(negedge sys_clk_in);
        // Released fields change, so a stale address cannot pass for a held one
        req_out = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~d};
    endtask

    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(negedge sys_clk_in);
        req_out = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(negedge sys_clk_in);
        req_out = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 8'hff};
        @(negedge sys_clk_in);
        data = rdata_in;
    endtask
endmodule // qdac_host_model

`default_nettype wire

// file: tb/tb_quad_dac_update_config.sv
// Self-checking bench for the update block against a behavioural register and update model.
// Assumes the host model drives the register bus; pin and temperatures are driven here.
`timescale 1ns/1ps
`default_nettype none

module tb_quad_dac_update_config;
    localparam int DB = 12;
    logic                sys_clk_in = 1'b0;
    logic                resetn_in = 1'b0;
    logic                pin_n = 1'b1;
    logic [9:0]          t_int = '0;
    logic [9:0]          t_ext = '0;
    qdac_pkg::qdac_req_s req;
    qdac_pkg::qdac_cfg_s cfg;
    logic [7:0]          rdata;
    logic [7:0]          rv;
    logic [4*DB-1:0]     code;
    logic [3:0]          upd;
    logic [3:0]          seen;
    logic                fa;
    logic                fb;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    int opm = 0;
    int dcfg = 0;
    int vref = 0;
    int msb[4];
    int lsb[4];
    int expc[4] = '{0, 0, 0, 0};

    always #2.5 sys_clk_in = ~sys_clk_in;

    qdac_update_ctrl #(.DAC_BITS(DB)) dut (
        .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .reg_req_in(req), .reg_rdata_out(rdata),
        .output_update_strobe_n_in(pin_n), .int_temp_in(t_int), .ext_temp_in(t_ext),
        .dac_code_out(code), .dac_updated_out(upd), .cfg_out(cfg),
        .a_follow_int_out(fa), .b_follow_ext_out(fb));
    qdac_host_model host (.sys_clk_in(sys_clk_in), .rdata_in(rdata), .req_out(req));

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            stop_test();
        end
    end

    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask

    // Pulses may land on the edge of the request or the next, so collect both
    task automatic watch(input int n);
        seen = upd;
        repeat (n) begin
            @(negedge sys_clk_in);
            seen = seen | upd;
        end
    endtask

    task automatic load_codes(input logic [3:0] m);
        for (int c = 0; c < 4; c++) begin
            if (m[c]) expc[c] = (msb[c] << 4) | (lsb[c] >> 4);
        end
        for (int c = 0; c < 4; c++) check(code[c*DB +: DB], expc[c]);
    endtask

    task automatic cfg_chk;
        check(cfg, {opm[0], opm[0], opm[1], opm[3], dcfg[3:0], dcfg[6], dcfg[7], vref[4]});
        check({fa, fb}, {opm[5], opm[6]});
    endtask

    function automatic logic [3:0] exp_upd(int m, int c);
        case (m)
            0: return 4'h1 << c;
            1: return (c == 1) ? 4'h3 : (c == 3) ? 4'hc : 4'h0;
            2: return (c == 3) ? 4'hf : 4'h0;
            default: return 4'h0;
        endcase
    endfunction

    task automatic dac_write(input int c, input logic [3:0] e);
        lsb[c] = $urandom & 8'hf0;
        msb[c] = $urandom & 8'hff;
        host.wr(8'(qdac_pkg::DAC_A_LSB_ADDR + 2 * c), 8'(lsb[c]));
        host.wr(8'(qdac_pkg::DAC_A_MSB_ADDR + 2 * c), 8'(msb[c]));
        watch(2);
        check(seen, e);
        load_codes(e);
    endtask

    initial begin
        void'($urandom(61015));
        repeat (12) @(negedge sys_clk_in);
        resetn_in = 1'b1;
        host.rd(qdac_pkg::OPMODE_ADDR, rv);
        check(rv, 8'h00);
        host.rd(qdac_pkg::CONV_CFG_ADDR, rv);
        check(rv, 8'h00);
        load_codes(4'h0);
        repeat (4) begin
            opm = $urandom & 8'h0b;
            dcfg = $urandom & 8'hcf;
            host.wr(qdac_pkg::OPMODE_ADDR, 8'(opm));
            host.wr(qdac_pkg::CONV_CFG_ADDR, 8'(dcfg));
            host.rd(qdac_pkg::OPMODE_ADDR, rv);
            check(rv, opm);
            host.rd(qdac_pkg::CONV_CFG_ADDR, rv);
            check(rv, dcfg);
            cfg_chk();
        end
        opm = 8'h08;
        host.wr(qdac_pkg::OPMODE_ADDR, 8'(opm));
        for (int m = 0; m < 4; m++) begin
            dcfg = (m << 4) | ($urandom & 8'hcf);
            host.wr(qdac_pkg::CONV_CFG_ADDR, 8'(dcfg));
            for (int c = 0; c < 4; c++) dac_write(c, exp_upd(m, c));
        end
        repeat (4) begin
            vref = $urandom & 8'h1f;
            host.wr(qdac_pkg::UPD_CMD_ADDR, 8'(vref));
            watch(2);
            check(seen, vref[3:0]);
            load_codes(vref[3:0]);
            host.rd(qdac_pkg::UPD_CMD_ADDR, rv);
            check(rv, vref & 8'h10);
            cfg_chk();
        end
        opm = 8'h00;
        host.wr(qdac_pkg::OPMODE_ADDR, 8'(opm));
        dcfg = dcfg & 8'hcf;
        host.wr(qdac_pkg::CONV_CFG_ADDR, 8'(dcfg));
        dac_write(1, 4'h0);
        pin_n = 1'b0;
        @(negedge sys_clk_in);
        pin_n = 1'b1;
        watch(4);
        check(seen, 4'hf);
        load_codes(4'hf);
        opm = 8'h08;
        host.wr(qdac_pkg::OPMODE_ADDR, 8'(opm));
        pin_n = 1'b0;
        watch(5);
        check(seen, 4'h0);
        pin_n = 1'b1;
        for (int k = 0; k < 2; k++) begin
            opm = 8'h68 | (k << 1);
            host.wr(qdac_pkg::OPMODE_ADDR, 8'(opm));
            t_int = 10'($urandom);
            t_ext = 10'($urandom);
            repeat (3) @(negedge sys_clk_in);
            check({fa, fb}, 2'b11);
            check(code[DB-1:0], k ? {t_int, 2'b00} : {t_int[9:2], 4'h0});
            check(code[2*DB-1:DB], k ? {t_ext, 2'b00} : {t_ext[9:2], 4'h0});
            cfg_chk();
        end
        stop_test();
    end
endmodule // tb_quad_dac_update_config

`default_nettype wire
